//--- hw/pss_seq.sv
// Power state sequencer: state machine, per-state supply settings
// and the APB register file that configures and reports it.
// Assumes an APB master on i_mclk; request and good pins are async.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pss_seq #(
  // Log2 of the waking minimum time; shorten in simulation
  parameter logic [4:0] WAKE_LOG2 = pss_pkg::WAKE_LOG2_DEF
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Asynchronous pins
  input wire logic i_wake_req,
  input wire logic i_sleep_req,
  input wire logic i_core_good,
  input wire logic i_pll_good,
  // Supply controls
  output logic o_core_buck_converter_en,
  output logic o_analog_buck_converter_en,
  output logic o_pll_linear_regulator_en,
  output logic o_io_supply_output_en,
  output logic o_core_buck_converter_pfm,
  output logic o_analog_buck_converter_pfm,
  output logic o_tile_clk_gate,
  output logic [2:0] o_state_code
);

  // Whole state of the block
  typedef struct packed {
    pss_pkg::pss_state_e state;
    logic [31:0] awake_cfg;
    logic [31:0] sleep_one_cfg;
    logic [31:0] sleep_two_cfg;
    pss_pkg::pss_cfg_s applied;
    pss_pkg::pss_cfg_s prev;
    logic tmr_start;
    logic [2:0] state_code;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pss_top_s;

  pss_top_s st_ff;
  pss_top_s nxt_st;

  logic [3:0] pins_sync;
  logic wake_s;
  logic sleep_s;
  logic core_good_s;
  logic pll_good_s;
  logic tmr_done;
  logic tmr_expired;
  logic [4:0] tmr_log2;
  logic supplies_good;
  logic setup;
  logic access;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_ok;
  logic [31:0] status_word;
  logic [31:0] cur_word;

  // Unpack a stored configuration word into the applied settings
  function automatic pss_pkg::pss_cfg_s to_cfg(input logic [31:0] w);
    pss_pkg::pss_cfg_s c;
    c.tile_gate = w[pss_pkg::BIT_TILE_GATE];
    c.analog_pfm = w[pss_pkg::BIT_ANALOG_PFM];
    c.core_pfm = w[pss_pkg::BIT_CORE_PFM];
    c.io_en = w[pss_pkg::BIT_IO_EN];
    c.pll_en = w[pss_pkg::BIT_PLL_EN];
    c.analog_en = w[pss_pkg::BIT_ANALOG_EN];
    c.core_en = w[pss_pkg::BIT_CORE_EN];
    return c;
  endfunction

  // Pack applied settings back into their bit positions
  function automatic logic [31:0] from_cfg(input pss_pkg::pss_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pss_pkg::BIT_TILE_GATE] = c.tile_gate;
    w[pss_pkg::BIT_ANALOG_PFM] = c.analog_pfm;
    w[pss_pkg::BIT_CORE_PFM] = c.core_pfm;
    w[pss_pkg::BIT_IO_EN] = c.io_en;
    w[pss_pkg::BIT_PLL_EN] = c.pll_en;
    w[pss_pkg::BIT_ANALOG_EN] = c.analog_en;
    w[pss_pkg::BIT_CORE_EN] = c.core_en;
    return w;
  endfunction

  // Binary code of a one-hot state for the status word
  function automatic logic [2:0] enc(input pss_pkg::pss_state_e s);
    logic [2:0] e;
    case (s)
      pss_pkg::ST_RESET: e = 3'h0;
      pss_pkg::ST_ASLEEP: e = 3'h1;
      pss_pkg::ST_FIRST_WAKE: e = 3'h2;
      pss_pkg::ST_SECOND_WAKE: e = 3'h3;
      pss_pkg::ST_AWAKE_WAIT: e = 3'h4;
      pss_pkg::ST_AWAKE: e = 3'h5;
      pss_pkg::ST_FIRST_SLEEP: e = 3'h6;
      pss_pkg::ST_SECOND_SLEEP: e = 3'h7;
      default: e = 3'h0;
    endcase
    return e;
  endfunction

  // Request and good pins come from outside the clock domain
  pss_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_wake_req, i_sleep_req, i_core_good, i_pll_good}),
    .o_sync(pins_sync)
  );

  assign wake_s = pins_sync[3];
  assign sleep_s = pins_sync[2];
  assign core_good_s = pins_sync[1];
  assign pll_good_s = pins_sync[0];

  // Duration source depends on which timed state is active
  always_comb begin
    case (st_ff.state)
      pss_pkg::ST_FIRST_SLEEP: begin
        tmr_log2 = st_ff.sleep_one_cfg[pss_pkg::DUR_LSB +: 5];
      end
      pss_pkg::ST_SECOND_SLEEP: begin
        tmr_log2 = st_ff.sleep_two_cfg[pss_pkg::DUR_LSB +: 5];
      end
      default: begin
        tmr_log2 = WAKE_LOG2;
      end
    endcase
  end

  // One timer serves every timed state; restarted on each entry
  pss_timer u_timer (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(st_ff.tmr_start),
    .i_log2(tmr_log2),
    .o_done(tmr_done)
  );

  // Done still shows the last run in a state's first cycle; mask it
  assign tmr_expired = tmr_done && !st_ff.tmr_start;

  // Only supplies that the state enables need to report good
  assign supplies_good = (!st_ff.applied.core_en || core_good_s) &&
                         (!st_ff.applied.pll_en || pll_good_s);

  // Status word as software sees it
  always_comb begin
    status_word = from_cfg(st_ff.applied);
    status_word[pss_pkg::STATE_LSB +: 3] = st_ff.state_code;
    status_word[pss_pkg::PREV_IO] = st_ff.prev.io_en;
    status_word[pss_pkg::PREV_PLL] = st_ff.prev.pll_en;
    status_word[pss_pkg::PREV_ANALOG] = st_ff.prev.analog_en;
    status_word[pss_pkg::PREV_CORE] = st_ff.prev.core_en;
  end

  // APB phases; a zero-wait-state slave, the answer registered in setup
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && st_ff.pready;

  // Read decode; unmapped addresses answer with an error and zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (i_paddr)
      pss_pkg::ADDR_AWAKE_CFG: rd_word = st_ff.awake_cfg;
      pss_pkg::ADDR_SLEEP_ONE_CFG: rd_word = st_ff.sleep_one_cfg;
      pss_pkg::ADDR_SLEEP_TWO_CFG: rd_word = st_ff.sleep_two_cfg;
      pss_pkg::ADDR_STATUS: rd_word = status_word;
      default: rd_hit = 1'b0;
    endcase
  end

  // Status is read-only; writing it is refused with an error
  assign wr_ok = rd_hit && (i_paddr != pss_pkg::ADDR_STATUS);

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tmr_start = 1'b0;

    // Bus answer: ready rises in setup, falls after the access
    if (setup) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = i_pwrite ? 32'h0000_0000 : rd_word;
      nxt_st.pslverr = i_pwrite ? !wr_ok : !rd_hit;
    end else if (access) begin
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
    end

    // Writes land only at the completing edge; read-only bits stay
    if (access && i_pwrite) begin
      case (i_paddr)
        pss_pkg::ADDR_AWAKE_CFG: begin
          nxt_st.awake_cfg = (i_pwdata & pss_pkg::AWAKE_WMASK) |
                             pss_pkg::CFG_RO_ONES;
        end
        pss_pkg::ADDR_SLEEP_ONE_CFG: begin
          nxt_st.sleep_one_cfg = (i_pwdata & pss_pkg::SLEEP_WMASK) |
                                 pss_pkg::CFG_RO_ONES;
        end
        pss_pkg::ADDR_SLEEP_TWO_CFG: begin
          nxt_st.sleep_two_cfg = (i_pwdata & pss_pkg::SLEEP_WMASK) |
                                 pss_pkg::CFG_RO_ONES;
        end
        default: begin
          nxt_st.awake_cfg = st_ff.awake_cfg;
        end
      endcase
    end

    // Sequencer transitions in code order
    case (st_ff.state)
      pss_pkg::ST_RESET: begin
        nxt_st.state = pss_pkg::ST_ASLEEP;
      end
      pss_pkg::ST_ASLEEP: begin
        if (wake_s) begin
          nxt_st.state = pss_pkg::ST_FIRST_WAKE;
        end
      end
      pss_pkg::ST_FIRST_WAKE: begin
        if (tmr_expired && supplies_good) begin
          nxt_st.state = pss_pkg::ST_SECOND_WAKE;
        end
      end
      pss_pkg::ST_SECOND_WAKE: begin
        if (tmr_expired && supplies_good) begin
          nxt_st.state = pss_pkg::ST_AWAKE_WAIT;
        end
      end
      pss_pkg::ST_AWAKE_WAIT: begin
        // Waits for the supplies only, no minimum time
        if (supplies_good) begin
          nxt_st.state = pss_pkg::ST_AWAKE;
        end
      end
      pss_pkg::ST_AWAKE: begin
        if (sleep_s) begin
          nxt_st.state = pss_pkg::ST_FIRST_SLEEP;
        end
      end
      pss_pkg::ST_FIRST_SLEEP: begin
        if (tmr_expired) begin
          nxt_st.state = pss_pkg::ST_SECOND_SLEEP;
        end
      end
      pss_pkg::ST_SECOND_SLEEP: begin
        if (tmr_expired) begin
          nxt_st.state = pss_pkg::ST_ASLEEP;
        end
      end
      default: begin
        nxt_st.state = pss_pkg::ST_RESET;
      end
    endcase

    // Entry bookkeeping: restart the timer and keep the old enables
    if (nxt_st.state != st_ff.state) begin
      nxt_st.tmr_start = 1'b1;
      nxt_st.prev = st_ff.applied;
    end

    // Configuration word that belongs to the next state
    case (nxt_st.state)
      pss_pkg::ST_ASLEEP: cur_word = pss_pkg::ASLEEP_CFG;
      pss_pkg::ST_FIRST_WAKE: cur_word = pss_pkg::WAKE_ONE_CFG;
      pss_pkg::ST_SECOND_WAKE: cur_word = pss_pkg::WAKE_TWO_CFG;
      pss_pkg::ST_AWAKE_WAIT: cur_word = pss_pkg::WAKE_TWO_CFG;
      pss_pkg::ST_AWAKE: cur_word = nxt_st.awake_cfg;
      pss_pkg::ST_FIRST_SLEEP: cur_word = nxt_st.sleep_one_cfg;
      pss_pkg::ST_SECOND_SLEEP: cur_word = nxt_st.sleep_two_cfg;
      default: cur_word = 32'h0000_0000;
    endcase
    // Settings follow the live register, so edits act at once
    nxt_st.applied = to_cfg(cur_word);
    if (nxt_st.state == pss_pkg::ST_RESET) begin
      nxt_st.applied = '0;
    end
    nxt_st.state_code = enc(nxt_st.state);
  end

  // Register the whole state; reset values are constants only
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_ff.state <= pss_pkg::ST_RESET;
      st_ff.awake_cfg <= pss_pkg::AWAKE_RST;
      st_ff.sleep_one_cfg <= pss_pkg::SLEEP_ONE_RST;
      st_ff.sleep_two_cfg <= pss_pkg::SLEEP_TWO_RST;
      st_ff.applied <= '0;
      st_ff.prev <= 7'h02;
      st_ff.tmr_start <= 1'b0;
      st_ff.state_code <= 3'h0;
      st_ff.prdata <= 32'h0000_0000;
      st_ff.pready <= 1'b0;
      st_ff.pslverr <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a flip-flop of the state
  assign o_prdata = st_ff.prdata;
  assign o_pready = st_ff.pready;
  assign o_pslverr = st_ff.pslverr;
  assign o_core_buck_converter_en = st_ff.applied.core_en;
  assign o_analog_buck_converter_en = st_ff.applied.analog_en;
  assign o_pll_linear_regulator_en = st_ff.applied.pll_en;
  assign o_io_supply_output_en = st_ff.applied.io_en;
  assign o_core_buck_converter_pfm = st_ff.applied.core_pfm;
  assign o_analog_buck_converter_pfm = st_ff.applied.analog_pfm;
  assign o_tile_clk_gate = st_ff.applied.tile_gate;
  assign o_state_code = st_ff.state_code;

endmodule // pss_seq
`default_nettype wire

//--- pkg/pss_pkg.sv
// Shared constants and types of the power state sequencer.
// Assumes a 32-bit APB register bus and one 100 MHz clock.
package pss_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_AWAKE_CFG = 8'h18;
  localparam logic [7:0] ADDR_SLEEP_ONE_CFG = 8'h1C;
  localparam logic [7:0] ADDR_SLEEP_TWO_CFG = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // Field positions in the configuration and status words
  localparam int BIT_CORE_EN = 0;
  localparam int BIT_ANALOG_EN = 1;
  localparam int BIT_PLL_EN = 4;
  localparam int BIT_IO_EN = 5;
  localparam int BIT_CORE_PFM = 8;
  localparam int BIT_ANALOG_PFM = 9;
  localparam int BIT_TILE_GATE = 14;
  localparam int DUR_LSB = 16;
  localparam int STATE_LSB = 16;
  localparam int PREV_CORE = 24;
  localparam int PREV_ANALOG = 25;
  localparam int PREV_PLL = 28;
  localparam int PREV_IO = 29;

  // Writable bits; bit 1 is read-only one in every config word
  localparam logic [31:0] AWAKE_WMASK = 32'h0000_4331;
  localparam logic [31:0] SLEEP_WMASK = 32'h001F_4331;
  localparam logic [31:0] CFG_RO_ONES = 32'h0000_0002;

  // Reset values, read-only bit 1 included
  localparam logic [31:0] AWAKE_RST = 32'h0000_0033;
  localparam logic [31:0] SLEEP_ONE_RST = 32'h0010_0022;
  localparam logic [31:0] SLEEP_TWO_RST = 32'h0010_0002;
  // Fixed words applied while asleep, while waking and in the awake wait
  localparam logic [31:0] WAKE_ONE_CFG = 32'h0000_0020;
  localparam logic [31:0] WAKE_TWO_CFG = 32'h0000_0033;
  localparam logic [31:0] ASLEEP_CFG = 32'h0000_0000;

  localparam logic [4:0] WAKE_LOG2_DEF = 5'h10;
  localparam int SYNC_W = 4;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_RESET = 8'h01,
    ST_ASLEEP = 8'h02,
    ST_FIRST_WAKE = 8'h04,
    ST_SECOND_WAKE = 8'h08,
    ST_AWAKE_WAIT = 8'h10,
    ST_AWAKE = 8'h20,
    ST_FIRST_SLEEP = 8'h40,
    ST_SECOND_SLEEP = 8'h80
  } pss_state_e;

  // Settings driven onto the supplies while a state is active
  typedef struct packed {
    logic tile_gate;
    logic analog_pfm;
    logic core_pfm;
    logic io_en;
    logic pll_en;
    logic analog_en;
    logic core_en;
  } pss_cfg_s;

endpackage

//--- hw/pss_sync.sv
// Two-flop synchroniser for the asynchronous request and good pins.
// Assumes the inputs are slow levels; pulses that fall between two clock edges drop.
`timescale 1ns/1ps
`default_nettype none
module pss_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [pss_pkg::SYNC_W-1:0] i_async,
  output logic [pss_pkg::SYNC_W-1:0] o_sync
);

  typedef struct packed {
    logic [pss_pkg::SYNC_W-1:0] meta;
    logic [pss_pkg::SYNC_W-1:0] sync;
  } pss_sync_s;

  pss_sync_s st_ff;
  pss_sync_s nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.meta = i_async;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.sync;

endmodule // pss_sync
`default_nettype wire

//--- hw/pss_timer.sv
// Duration timer: restarted by a pulse, done after 2**log2 cycles.
// Assumes log2 is held stable while the timer runs.
`timescale 1ns/1ps
`default_nettype none
module pss_timer (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [4:0] i_log2,
  output logic o_done
);

  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } pss_tmr_s;

  pss_tmr_s st_ff;
  pss_tmr_s nxt_st;
  logic [31:0] limit;

  // Counter cleared on entry, compared with 2**n minus one
  always_comb begin
    limit = (32'h0000_0001 << i_log2) - 32'h0000_0001;
    nxt_st = st_ff;
    if (i_start) begin
      nxt_st.cnt = 32'h0000_0000;
      nxt_st.done = 1'b0;
    end else if (!st_ff.done) begin
      // At or past the limit, so a shortened duration cannot overrun
      if (st_ff.cnt >= limit) begin
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_done = st_ff.done;

endmodule // pss_timer
`default_nettype wire

//--- verif/pss_seq_monitor.sv
// Port checker of the power state sequencer, bound into pss_seq.
// Assumes one clock and the asynchronous active-high reset of the top.
`timescale 1ns/1ps
`default_nettype none
module pss_seq_monitor #(
  parameter logic [4:0] WAKE_LOG2 = pss_pkg::WAKE_LOG2_DEF
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_wake_req,
  input wire logic i_sleep_req,
  input wire logic i_core_good,
  input wire logic i_pll_good,
  input wire logic o_core_buck_converter_en,
  input wire logic o_analog_buck_converter_en,
  input wire logic o_pll_linear_regulator_en,
  input wire logic o_io_supply_output_en,
  input wire logic o_core_buck_converter_pfm,
  input wire logic o_analog_buck_converter_pfm,
  input wire logic o_tile_clk_gate,
  input wire logic [2:0] o_state_code
);
  localparam int WAKE_MIN = (1 << WAKE_LOG2) - 1;
  logic [15:0] dwell_ff;
  logic [15:0] nxt_dwell;
  logic [2:0] last_ff;
  logic rd_acc;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Read access cycle with the answer present
  assign rd_acc = o_pready && i_psel && i_penable && !i_pwrite;

  // Cycles spent in the current state; saturates so long states stay sane
  always_comb begin
    nxt_dwell = dwell_ff;
    if (o_state_code != last_ff) nxt_dwell = 16'h0000;
    else if (dwell_ff != 16'hFFFF) nxt_dwell = dwell_ff + 16'h0001;
  end

  // Helper registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dwell_ff <= 16'h0000;
      last_ff <= 3'h0;
    end else begin
      dwell_ff <= nxt_dwell;
      last_ff <= o_state_code;
    end
  end

  sequence s_first_sleep_hold;
    (o_state_code == 3'h6)[*4];
  endsequence
  sequence s_second_sleep_hold;
    (o_state_code == 3'h7)[*4];
  endsequence

  property p_order;
    last_ff != 3'h0 && o_state_code != last_ff |->
      o_state_code == ((last_ff == 3'h7) ? 3'h1 : last_ff + 3'h1);
  endproperty
  a_order: assert property (p_order)
    else $error("state code left its sequence order");

  property p_wake_min;
    ((o_state_code == 3'h3 && last_ff == 3'h2) ||
     (o_state_code == 3'h4 && last_ff == 3'h3)) |-> dwell_ff >= WAKE_MIN;
  endproperty
  a_wake_min: assert property (p_wake_min)
    else $error("waking phase left before its minimum time");

  property p_sleep_one;
    o_state_code == 3'h6 && last_ff == 3'h5 |-> s_first_sleep_hold;
  endproperty
  a_sleep_one: assert property (p_sleep_one)
    else $error("first sleep phase ended too early");

  property p_sleep_two;
    o_state_code == 3'h7 && last_ff == 3'h6 |-> s_second_sleep_hold;
  endproperty
  a_sleep_two: assert property (p_sleep_two)
    else $error("second sleep phase ended too early");

  property p_analog_on;
    o_state_code >= 3'h3 |-> o_analog_buck_converter_en;
  endproperty
  a_analog_on: assert property (p_analog_on)
    else $error("analog converter off in a configured state");

  property p_status_rd;
    rd_acc && i_paddr == pss_pkg::ADDR_STATUS && $stable(o_state_code) &&
      $stable({o_tile_clk_gate, o_core_buck_converter_en}) |->
      o_prdata[18:16] == o_state_code && o_prdata[14] == o_tile_clk_gate &&
      o_prdata[0] == o_core_buck_converter_en;
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status read disagrees with applied state");

  property p_cfg_rd;
    rd_acc && i_paddr != pss_pkg::ADDR_STATUS && !o_pslverr |->
      o_prdata[1] && o_prdata[31:21] == 11'h000;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config read shows bad fixed bits");

  property p_status_wr;
    o_pready && i_psel && i_pwrite && i_paddr == pss_pkg::ADDR_STATUS |->
      o_pslverr;
  endproperty
  a_status_wr: assert property (p_status_wr)
    else $error("status write was not refused");
endmodule // pss_seq_monitor

bind pss_seq pss_seq_monitor #(.WAKE_LOG2(WAKE_LOG2)) u_monitor (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_wake_req(i_wake_req), .i_sleep_req(i_sleep_req),
  .i_core_good(i_core_good), .i_pll_good(i_pll_good),
  .o_core_buck_converter_en(o_core_buck_converter_en),
  .o_analog_buck_converter_en(o_analog_buck_converter_en),
  .o_pll_linear_regulator_en(o_pll_linear_regulator_en),
  .o_io_supply_output_en(o_io_supply_output_en),
  .o_core_buck_converter_pfm(o_core_buck_converter_pfm),
  .o_analog_buck_converter_pfm(o_analog_buck_converter_pfm),
  .o_tile_clk_gate(o_tile_clk_gate), .o_state_code(o_state_code));
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench of the power state sequencer over APB.
// Assumes pss_seq with a shortened waking time and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
  localparam logic [31:0] AW_W = 32'h0000_0331;
  localparam logic [31:0] S1_W = 32'h0002_4120;
  localparam logic [31:0] S2_W = 32'h0003_0211;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wake = 1'b0;
  logic slp = 1'b0;
  logic cgood = 1'b0;
  logic pgood = 1'b0;
  wire pss_pkg::pss_cfg_s outs;
  logic [2:0] code;
  int err_total = 0;
  int checks = 0;
  logic [7:0] cfg_a [3] = '{pss_pkg::ADDR_AWAKE_CFG,
    pss_pkg::ADDR_SLEEP_ONE_CFG, pss_pkg::ADDR_SLEEP_TWO_CFG};
  logic [31:0] cfg_rst [3] = '{pss_pkg::AWAKE_RST, pss_pkg::SLEEP_ONE_RST,
    pss_pkg::SLEEP_TWO_RST};
  logic [31:0] cfg_ones [3] = '{32'h0000_4333, 32'h001F_4333, 32'h001F_4333};
  logic [31:0] cfg_w [3] = '{AW_W, S1_W, S2_W};

  pss_seq #(.WAKE_LOG2(5'h03)) dut (
    .i_mclk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_wake_req(wake), .i_sleep_req(slp), .i_core_good(cgood),
    .i_pll_good(pgood), .o_core_buck_converter_en(outs.core_en),
    .o_analog_buck_converter_en(outs.analog_en),
    .o_pll_linear_regulator_en(outs.pll_en),
    .o_io_supply_output_en(outs.io_en),
    .o_core_buck_converter_pfm(outs.core_pfm),
    .o_analog_buck_converter_pfm(outs.analog_pfm),
    .o_tile_clk_gate(outs.tile_gate), .o_state_code(code));

  // Supply settings expected from a configuration word
  function automatic pss_pkg::pss_cfg_s to_cfg(input logic [31:0] w);
    return {w[14], w[9], w[8], w[5], w[4], w[1], w[0]};
  endfunction

  // One APB transfer; an idle edge follows so psel is never set twice
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Bounded wait for a state code
  task automatic wait_code(input logic [2:0] c);
    int n;
    n = 0;
    while (code !== c && n < 2000) begin
      n++;
      @(posedge clk);
    end
    `CHK("state reached", c, code)
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, cfg_a[i], 32'h0, q, e);
      `CHK("config reset", cfg_rst[i], q)
    end
    apb(1'b0, pss_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("status state", 3'h1, q[18:16])
    `CHK("status applied", 16'h0000, q[15:0])
    `CHK("asleep outputs", 7'h00, outs)
  endtask

  // Masks, read-only bits, refused and unmapped accesses
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, cfg_a[i], 32'hFFFF_FFFF, q, e);
      apb(1'b0, cfg_a[i], 32'h0, q, e);
      `CHK("config ones", cfg_ones[i], q)
      apb(1'b1, cfg_a[i], cfg_w[i], q, e);
      apb(1'b0, cfg_a[i], 32'h0, q, e);
      `CHK("config word", cfg_w[i] | 32'h2, q)
    end
    apb(1'b1, pss_pkg::ADDR_STATUS, 32'hFFFF_FFFF, q, e);
    `CHK("status write err", 1'b1, e)
    apb(1'b0, pss_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("status unchanged", 16'h0000, q[15:0])
    apb(1'b0, 8'h28, 32'h0, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
  endtask

  // Full wake and sleep round with a live edit while awake
  task automatic t_cycle();
    logic [31:0] q;
    logic e;
    int n;
    // Core good held low: the second waking phase must wait for it
    cgood <= 1'b0;
    pgood <= 1'b1;
    wake <= 1'b1;
    wait_code(3'h3);
    repeat (30) @(posedge clk);
    `CHK("held for core good", 3'h3, code)
    cgood <= 1'b1;
    wait_code(3'h5);
    wake <= 1'b0;
    `CHK("awake outputs", to_cfg(AW_W | 32'h2), outs)
    apb(1'b0, pss_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("awake status", 32'h3305_0333, q)
    apb(1'b1, pss_pkg::ADDR_AWAKE_CFG, AW_W | 32'h4000, q, e);
    @(posedge clk);
    `CHK("live edit", to_cfg(AW_W | 32'h4002), outs)
    slp <= 1'b1;
    wait_code(3'h6);
    slp <= 1'b0;
    `CHK("sleep one outputs", to_cfg(S1_W | 32'h2), outs)
    n = 0;
    while (code === 3'h6 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK("sleep one length", 1'b1, n >= 4 && n <= 7)
    `CHK("sleep two outputs", to_cfg(S2_W | 32'h2), outs)
    apb(1'b0, pss_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("sleep status", 32'h2207_0213, q)
    wait_code(3'h1);
    `CHK("back asleep", 7'h00, outs)
  endtask

  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Watchdog far beyond the expected run of under two hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_cycle();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
